/* File: r8x_pkg.sv */
// Summary of operation
// (RL1) return resumes right after the call
// (RL2) jump loads target, no save, two cycles
// (RL3) skips test byte or bit, discard next
// (RL4) skip costs one cycle, two when taken
// (RL5) writing program counter low takes two cycles
// (RL6) paired watchdog clears act only when consecutive
// (RL7) bit set/clear changes only that bit
// (RL8) table read: high to table byte, low to memory
// (RL9) add/subtract update zero, carry, aux, overflow
// (RL10) logic ops touch only zero flag
// (RL11) increment/decrement touch only zero flag
// (RL12) plain rotate no flags; through-carry uses carry
// (RL13) moves take one cycle, no flags
// (RL14) bit skip on zero, companion on one
// (RL15) inc/dec skip: write result, skip if zero
// (RL16) skip-zero-move copies byte, skips when zero
// (RL17) return-immediate restores address, loads accumulator
// (RL18) nibble swap, to memory or accumulator, no flags
// (RL19) bit index zero to seven selects bit
// (RL20) power down halts, one cycle, updates flags
// (RL21) instruction cycle is four clocks
// (RL22) power down sets pd, clears timeout, watchdog
// (RL23) plain watchdog clear clears counter and flags
package r8x_pkg;

  localparam int IC_CLOCKS = 4;
  localparam logic [1:0] PHASE_LAST = 2'(IC_CLOCKS - 1);

  // instruction word fields
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 10;
  localparam int BIT_MSB = 9;
  localparam int BIT_LSB = 7;
  localparam int MADDR_MSB = 6;
  localparam int IMM_MSB = 7;
  localparam int TBL_HI_MSB = 15;
  localparam int TBL_HI_LSB = 8;

  // special data memory addresses
  localparam logic [6:0] MEM_ACC = 7'h05;
  localparam logic [6:0] MEM_PCL = 7'h06;
  localparam logic [6:0] MEM_TBLP = 7'h07;
  localparam logic [6:0] MEM_TABLE_HIGH_BYTE = 7'h08;
  localparam logic [6:0] MEM_STATUS = 7'h0a;

  // register port byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_ACC = 8'h0c;
  localparam logic [7:0] REG_TABLE_HIGH_BYTE = 8'h10;

  localparam int CTRL_RUN = 0;
  localparam int CTRL_WDT_EN = 1;
  localparam int CTRL_WAKE = 2;
  localparam logic CTRL_RUN_RESET = 1'h0;
  localparam logic CTRL_WDT_EN_RESET = 1'h0;

  localparam int ST_C = 0;
  localparam int ST_AC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_PDF = 4;
  localparam int ST_TO = 5;
  localparam int ST_HALT = 6;

  typedef enum logic [5:0] {
    OP_NOP, OP_ADD_A, OP_ADDM, OP_ADD_I, OP_ADC_A, OP_ADCM, OP_SUB_A, OP_SUBM,
    OP_SUB_I, OP_SBC_A, OP_SBCM, OP_AND_A, OP_ANDM, OP_AND_I, OP_OR_A, OP_ORM,
    OP_OR_I, OP_XOR_A, OP_XORM, OP_XOR_I, OP_CPL, OP_CPLA, OP_INC, OP_INCA,
    OP_DEC, OP_DECA, OP_RR, OP_RRA, OP_RRC, OP_RRCA, OP_RL, OP_RLA,
    OP_RLC, OP_RLCA, OP_MOV_AM, OP_MOV_MA, OP_MOV_I, OP_CLR, OP_SET, OP_CLRB,
    OP_SETB, OP_SZ, OP_SZA, OP_SZB, OP_SNZB, OP_SIZ, OP_SIZA, OP_SDZ,
    OP_SDZA, OP_SWAP, OP_SWAPA, OP_JMP, OP_CALL, OP_RET, OP_RETA, OP_TRDC,
    OP_TRDL, OP_CLRWDT, OP_CLRWDT1, OP_CLRWDT2, OP_HALT, OP_DAA
  } r8x_op_t;

  typedef enum logic [1:0] {PRE_NONE, PRE_FIRST, PRE_SECOND} r8x_pre_t;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } r8x_flags_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } r8x_bus_req_t;

endpackage

/* File: r8x_core.sv */
`timescale 1ns/100ps
module r8x_core #(
  parameter int PAW = 10,
  parameter int STACK_DEPTH = 4,
  parameter int WDT_LIMIT = 8192
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // program memory
  output logic [PAW-1:0] prog_addr,
  input wire logic [15:0] prog_data,
  // wake from power down
  input wire logic wake,
  // register port
  input wire r8x_pkg::r8x_bus_req_t bus_req,
  output logic [15:0] bus_rdata,
  // core status
  output logic halted,
  output logic watchdog_timeout_flag,
  output logic power_down_flag
);

  localparam int SPW = $clog2(STACK_DEPTH);
  localparam int WDW = $clog2(WDT_LIMIT);

  // jump field is ten bits wide, last page needs at least nine
  if (PAW < 9 || PAW > 10) begin : g_bad_paw
    $error("program address width must be 9 or 10");
  end
  if (STACK_DEPTH < 2 || (1 << SPW) != STACK_DEPTH) begin : g_bad_stack
    $error("stack depth must be a power of two, at least 2");
  end
  if (WDT_LIMIT < 2) begin : g_bad_wdt
    $error("watchdog limit must be at least 2");
  end

  logic [1:0] phase;
  logic [PAW-1:0] pc;
  logic [7:0] accumulator;
  logic [7:0] table_high_byte;
  r8x_pkg::r8x_flags_t flags;
  logic [7:0] dmem [0:127];
  logic [PAW-1:0] stack [0:STACK_DEPTH-1];
  logic [SPW-1:0] sp;
  logic bubble;
  logic tbl_pending;
  logic [PAW-1:0] tbl_addr;
  logic [6:0] tbl_dst;
  logic run;
  logic wdt_en;
  r8x_pkg::r8x_pre_t pre_state;
  logic [WDW-1:0] wdt_count;

  r8x_pkg::r8x_op_t op;
  logic [6:0] maddr;
  logic [2:0] bsel;
  logic [7:0] imm;
  logic [7:0] mval;
  logic [7:0] status_byte;
  logic step;
  logic exec;
  logic tbl_load;
  logic wake_req;
  logic wdt_tick;
  logic wdt_tmo;
  logic wdt_clear;
  logic pair_ok;

  // alu
  logic [7:0] addend;
  logic cin;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] daa_adj;
  logic [8:0] daa9;
  logic [7:0] res;
  logic to_acc;
  logic to_mem;
  logic arith;
  logic fz;
  logic fc;
  logic new_c;
  logic skip;
  logic jump;
  logic push;
  logic pop;
  logic tbl;
  logic tbl_last;
  logic halt_req;
  logic clr_wdt;
  logic pre1;
  logic pre2;
  logic pcl_write;

  assign op = r8x_pkg::r8x_op_t'(prog_data[r8x_pkg::OP_MSB:r8x_pkg::OP_LSB]);
  assign maddr = prog_data[r8x_pkg::MADDR_MSB:0];
  assign bsel = prog_data[r8x_pkg::BIT_MSB:r8x_pkg::BIT_LSB];
  assign imm = prog_data[r8x_pkg::IMM_MSB:0];

  // execute once per instruction cycle, on its last clock
  assign step = ce && run && !halted && phase == r8x_pkg::PHASE_LAST; // see RL21
  assign exec = step && !bubble;
  assign tbl_load = step && bubble && tbl_pending; // see RL8
  assign wake_req = ce && (wake ||
    (bus_req.wr && bus_req.addr == r8x_pkg::REG_CTRL && bus_req.wdata[r8x_pkg::CTRL_WAKE]));

  always_comb begin
    status_byte = 8'h00;
    status_byte[r8x_pkg::ST_C] = flags.c;
    status_byte[r8x_pkg::ST_AC] = flags.ac;
    status_byte[r8x_pkg::ST_Z] = flags.z;
    status_byte[r8x_pkg::ST_OV] = flags.ov;
    status_byte[r8x_pkg::ST_PDF] = power_down_flag;
    status_byte[r8x_pkg::ST_TO] = watchdog_timeout_flag;
    status_byte[r8x_pkg::ST_HALT] = halted;
  end

  always_comb begin
    case (maddr)
      r8x_pkg::MEM_ACC: mval = accumulator;
      r8x_pkg::MEM_PCL: mval = pc[7:0];
      r8x_pkg::MEM_TABLE_HIGH_BYTE: mval = table_high_byte;
      r8x_pkg::MEM_STATUS: mval = status_byte;
      default: mval = dmem[maddr];
    endcase
  end

  // subtract is add of the complement; carry set means no borrow
  always_comb begin
    addend = (op == r8x_pkg::OP_ADD_I || op == r8x_pkg::OP_SUB_I) ? imm : mval;
    cin = 1'b0;
    case (op)
      r8x_pkg::OP_SUB_A, r8x_pkg::OP_SUBM, r8x_pkg::OP_SUB_I: begin
        addend = ~addend;
        cin = 1'b1;
      end
      r8x_pkg::OP_SBC_A, r8x_pkg::OP_SBCM: begin
        addend = ~addend;
        cin = flags.c;
      end
      r8x_pkg::OP_ADC_A, r8x_pkg::OP_ADCM: cin = flags.c;
      default: cin = 1'b0;
    endcase
    sum9 = {1'b0, accumulator} + {1'b0, addend} + {8'h00, cin};
    sum5 = {1'b0, accumulator[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
    daa_adj = 8'h00;
    if (accumulator[3:0] > 4'h9 || flags.ac) begin
      daa_adj[3:0] = 4'h6;
    end
    if (accumulator[7:4] > 4'h9 || flags.c) begin
      daa_adj[7:4] = 4'h6;
    end
    daa9 = {1'b0, accumulator} + {1'b0, daa_adj};
  end

  always_comb begin
    res = 8'h00;
    to_acc = 1'b0;
    to_mem = 1'b0;
    arith = 1'b0;
    fz = 1'b0;
    fc = 1'b0;
    new_c = flags.c;
    skip = 1'b0;
    jump = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    tbl = 1'b0;
    tbl_last = 1'b0;
    halt_req = 1'b0;
    clr_wdt = 1'b0;
    pre1 = 1'b0;
    pre2 = 1'b0;
    case (op)
      r8x_pkg::OP_ADD_A, r8x_pkg::OP_ADC_A, r8x_pkg::OP_SUB_A, r8x_pkg::OP_SBC_A,
      r8x_pkg::OP_ADD_I, r8x_pkg::OP_SUB_I: begin
        res = sum9[7:0];
        to_acc = 1'b1;
        arith = 1'b1; // see RL9
      end
      r8x_pkg::OP_ADDM, r8x_pkg::OP_ADCM, r8x_pkg::OP_SUBM, r8x_pkg::OP_SBCM: begin
        res = sum9[7:0];
        to_mem = 1'b1;
        arith = 1'b1; // see RL9
      end
      r8x_pkg::OP_AND_A, r8x_pkg::OP_AND_I, r8x_pkg::OP_ANDM: begin
        res = accumulator & ((op == r8x_pkg::OP_AND_I) ? imm : mval);
        to_acc = op != r8x_pkg::OP_ANDM;
        to_mem = op == r8x_pkg::OP_ANDM;
        fz = 1'b1; // see RL10
      end
      r8x_pkg::OP_OR_A, r8x_pkg::OP_OR_I, r8x_pkg::OP_ORM: begin
        res = accumulator | ((op == r8x_pkg::OP_OR_I) ? imm : mval);
        to_acc = op != r8x_pkg::OP_ORM;
        to_mem = op == r8x_pkg::OP_ORM;
        fz = 1'b1; // see RL10
      end
      r8x_pkg::OP_XOR_A, r8x_pkg::OP_XOR_I, r8x_pkg::OP_XORM: begin
        res = accumulator ^ ((op == r8x_pkg::OP_XOR_I) ? imm : mval);
        to_acc = op != r8x_pkg::OP_XORM;
        to_mem = op == r8x_pkg::OP_XORM;
        fz = 1'b1; // see RL10
      end
      r8x_pkg::OP_CPL, r8x_pkg::OP_CPLA: begin
        res = ~mval;
        to_acc = op == r8x_pkg::OP_CPLA;
        to_mem = op == r8x_pkg::OP_CPL;
        fz = 1'b1; // see RL10
      end
      r8x_pkg::OP_INC, r8x_pkg::OP_INCA, r8x_pkg::OP_DEC, r8x_pkg::OP_DECA: begin
        res = (op == r8x_pkg::OP_INC || op == r8x_pkg::OP_INCA) ? mval + 8'h01 : mval - 8'h01;
        to_acc = op == r8x_pkg::OP_INCA || op == r8x_pkg::OP_DECA;
        to_mem = !to_acc;
        fz = 1'b1; // see RL11
      end
      r8x_pkg::OP_RR, r8x_pkg::OP_RRA: begin
        res = {mval[0], mval[7:1]}; // see RL12
        to_acc = op == r8x_pkg::OP_RRA;
        to_mem = !to_acc;
      end
      r8x_pkg::OP_RL, r8x_pkg::OP_RLA: begin
        res = {mval[6:0], mval[7]}; // see RL12
        to_acc = op == r8x_pkg::OP_RLA;
        to_mem = !to_acc;
      end
      r8x_pkg::OP_RRC, r8x_pkg::OP_RRCA: begin
        res = {flags.c, mval[7:1]};
        fc = 1'b1;
        new_c = mval[0]; // see RL12
        to_acc = op == r8x_pkg::OP_RRCA;
        to_mem = !to_acc;
      end
      r8x_pkg::OP_RLC, r8x_pkg::OP_RLCA: begin
        res = {mval[6:0], flags.c};
        fc = 1'b1;
        new_c = mval[7]; // see RL12
        to_acc = op == r8x_pkg::OP_RLCA;
        to_mem = !to_acc;
      end
      r8x_pkg::OP_MOV_AM: begin
        res = mval;
        to_acc = 1'b1; // see RL13
      end
      r8x_pkg::OP_MOV_MA: begin
        res = accumulator;
        to_mem = 1'b1; // see RL13
      end
      r8x_pkg::OP_MOV_I: begin
        res = imm;
        to_acc = 1'b1; // see RL13
      end
      r8x_pkg::OP_CLR: to_mem = 1'b1;
      r8x_pkg::OP_SET: begin
        res = 8'hff;
        to_mem = 1'b1;
      end
      r8x_pkg::OP_CLRB: begin
        res = mval & ~(8'h01 << bsel); // see RL7, see RL19
        to_mem = 1'b1;
      end
      r8x_pkg::OP_SETB: begin
        res = mval | (8'h01 << bsel); // see RL7, see RL19
        to_mem = 1'b1;
      end
      r8x_pkg::OP_SZ: skip = mval == 8'h00; // see RL3
      r8x_pkg::OP_SZA: begin
        res = mval;
        to_acc = 1'b1;
        skip = mval == 8'h00; // see RL16
      end
      r8x_pkg::OP_SZB: skip = !mval[bsel]; // see RL14
      r8x_pkg::OP_SNZB: skip = mval[bsel]; // see RL14
      r8x_pkg::OP_SIZ, r8x_pkg::OP_SIZA, r8x_pkg::OP_SDZ, r8x_pkg::OP_SDZA: begin
        res = (op == r8x_pkg::OP_SIZ || op == r8x_pkg::OP_SIZA) ? mval + 8'h01 : mval - 8'h01;
        to_acc = op == r8x_pkg::OP_SIZA || op == r8x_pkg::OP_SDZA;
        to_mem = !to_acc;
        skip = res == 8'h00; // see RL15
      end
      r8x_pkg::OP_SWAP, r8x_pkg::OP_SWAPA: begin
        res = {mval[3:0], mval[7:4]}; // see RL18
        to_acc = op == r8x_pkg::OP_SWAPA;
        to_mem = !to_acc;
      end
      r8x_pkg::OP_JMP: jump = 1'b1; // see RL2
      r8x_pkg::OP_CALL: begin
        jump = 1'b1;
        push = 1'b1;
      end
      r8x_pkg::OP_RET: pop = 1'b1; // see RL1
      r8x_pkg::OP_RETA: begin
        pop = 1'b1;
        res = imm;
        to_acc = 1'b1; // see RL17
      end
      r8x_pkg::OP_TRDC: tbl = 1'b1;
      r8x_pkg::OP_TRDL: begin
        tbl = 1'b1;
        tbl_last = 1'b1;
      end
      r8x_pkg::OP_CLRWDT: clr_wdt = 1'b1;
      r8x_pkg::OP_CLRWDT1: pre1 = 1'b1;
      r8x_pkg::OP_CLRWDT2: pre2 = 1'b1;
      r8x_pkg::OP_HALT: halt_req = 1'b1;
      r8x_pkg::OP_DAA: begin
        res = daa9[7:0];
        to_mem = 1'b1;
        fc = 1'b1;
        new_c = flags.c | daa9[8];
      end
      default: res = 8'h00;
    endcase
  end

  assign pcl_write = to_mem && maddr == r8x_pkg::MEM_PCL;
  assign pair_ok = (pre1 && pre_state == r8x_pkg::PRE_SECOND) ||
    (pre2 && pre_state == r8x_pkg::PRE_FIRST); // see RL6
  assign wdt_clear = exec && (clr_wdt || pair_ok || halt_req); // see RL22, see RL23
  assign wdt_tick = ce && wdt_en && phase == r8x_pkg::PHASE_LAST;
  assign wdt_tmo = wdt_tick && !wdt_clear && wdt_count == WDW'(WDT_LIMIT - 1);

  always_ff @(posedge clk) begin
    if (reset) begin
      phase <= 2'h0;
    end else if (ce) begin
      phase <= phase + 2'h1; // see RL21
    end
  end

  // program flow: every redirect burns the following instruction cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pc <= '0;
      sp <= '0;
      bubble <= 1'b0;
      tbl_pending <= 1'b0;
      tbl_addr <= '0;
      tbl_dst <= 7'h00;
      halted <= 1'b0;
    end else if (wdt_tmo) begin
      pc <= '0;
      sp <= '0;
      bubble <= 1'b0;
      tbl_pending <= 1'b0;
      halted <= 1'b0;
    end else begin
      if (wake_req) begin
        halted <= 1'b0;
      end
      if (step && bubble) begin
        bubble <= 1'b0;
        tbl_pending <= 1'b0;
      end else if (exec) begin
        if (pop) begin
          pc <= stack[sp - 1'b1]; // see RL1, see RL17
          sp <= sp - 1'b1;
          bubble <= 1'b1;
        end else if (jump) begin
          if (push) begin
            stack[sp] <= pc + 1'b1;
            sp <= sp + 1'b1;
          end
          pc <= prog_data[PAW-1:0]; // see RL2
          bubble <= 1'b1;
        end else if (pcl_write) begin
          pc <= {pc[PAW-1:8], res}; // see RL5
          bubble <= 1'b1;
        end else if (skip) begin
          pc <= pc + PAW'(2); // see RL4
          bubble <= 1'b1;
        end else if (tbl) begin
          pc <= pc + 1'b1;
          bubble <= 1'b1;
          tbl_pending <= 1'b1;
          tbl_dst <= maddr;
          tbl_addr <= tbl_last ? {{(PAW-8){1'b1}}, dmem[r8x_pkg::MEM_TBLP]}
                               : {pc[PAW-1:8], dmem[r8x_pkg::MEM_TBLP]}; // see RL8
        end else begin
          pc <= pc + 1'b1;
        end
        if (halt_req) begin
          halted <= 1'b1; // see RL20
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prog_addr <= '0;
    end else if (ce) begin
      prog_addr <= tbl_pending ? tbl_addr : pc;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      accumulator <= 8'h00;
    end else if (exec && (to_acc || (to_mem && maddr == r8x_pkg::MEM_ACC))) begin
      accumulator <= res;
    end else if (tbl_load && tbl_dst == r8x_pkg::MEM_ACC) begin
      // table low byte aimed at the accumulator's address lands in it
      accumulator <= prog_data[7:0]; // see RL8
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      table_high_byte <= 8'h00;
    end else if (tbl_load) begin
      table_high_byte <= prog_data[r8x_pkg::TBL_HI_MSB:r8x_pkg::TBL_HI_LSB]; // see RL8
    end
  end

  // data memory keeps its contents across power down and reset
  always_ff @(posedge clk) begin
    if (tbl_load) begin
      dmem[tbl_dst] <= prog_data[7:0]; // see RL8
    end else if (exec && to_mem) begin
      dmem[maddr] <= res; // see RL7
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flags <= '0;
    end else if (exec) begin
      if (to_mem && maddr == r8x_pkg::MEM_STATUS) begin
        flags <= res[3:0];
      end
      if (arith || fz) begin
        flags.z <= res == 8'h00; // see RL9, see RL10, see RL11
      end
      if (arith) begin
        flags.c <= sum9[8]; // see RL9
        flags.ac <= sum5[4];
        flags.ov <= (accumulator[7] == addend[7]) && (sum9[7] != accumulator[7]);
      end else if (fc) begin
        flags.c <= new_c; // see RL12
      end
    end
  end

  // a clear in the same cycle as the final tick prevents the timeout and clears the flag
  always_ff @(posedge clk) begin
    if (reset) begin
      watchdog_timeout_flag <= 1'b0;
      power_down_flag <= 1'b0;
    end else begin
      if (wdt_tmo) begin
        watchdog_timeout_flag <= 1'b1;
      end else if (exec && (clr_wdt || pair_ok || halt_req)) begin
        watchdog_timeout_flag <= 1'b0; // see RL6, see RL22, see RL23
      end
      if (exec && halt_req) begin
        power_down_flag <= 1'b1; // see RL20, see RL22
      end else if (exec && (clr_wdt || pair_ok)) begin
        power_down_flag <= 1'b0; // see RL6, see RL23
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pre_state <= r8x_pkg::PRE_NONE;
    end else if (exec) begin
      if (pre1) begin
        pre_state <= pair_ok ? r8x_pkg::PRE_NONE : r8x_pkg::PRE_FIRST; // see RL6
      end else if (pre2) begin
        pre_state <= pair_ok ? r8x_pkg::PRE_NONE : r8x_pkg::PRE_SECOND; // see RL6
      end else begin
        pre_state <= r8x_pkg::PRE_NONE;
      end
    end
  end

  // one counter stands for prescaler and watchdog together
  always_ff @(posedge clk) begin
    if (reset) begin
      wdt_count <= '0;
    end else if (wdt_clear || wdt_tmo) begin
      wdt_count <= '0; // see RL22, see RL23
    end else if (wdt_tick) begin
      wdt_count <= wdt_count + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      run <= r8x_pkg::CTRL_RUN_RESET;
      wdt_en <= r8x_pkg::CTRL_WDT_EN_RESET;
      bus_rdata <= 16'h0000;
    end else if (ce) begin
      bus_rdata <= 16'h0000;
      if (bus_req.wr && bus_req.addr == r8x_pkg::REG_CTRL) begin
        run <= bus_req.wdata[r8x_pkg::CTRL_RUN];
        wdt_en <= bus_req.wdata[r8x_pkg::CTRL_WDT_EN];
      end
      if (bus_req.rd) begin
        case (bus_req.addr)
          r8x_pkg::REG_CTRL: bus_rdata <= {14'h0000, wdt_en, run};
          r8x_pkg::REG_STATUS: bus_rdata <= {8'h00, status_byte};
          r8x_pkg::REG_PC: bus_rdata <= 16'(pc);
          r8x_pkg::REG_ACC: bus_rdata <= {8'h00, accumulator};
          r8x_pkg::REG_TABLE_HIGH_BYTE: bus_rdata <= {8'h00, table_high_byte};
          default: bus_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule

/* File: r8x_core_props.sv */
`timescale 1ns/100ps
module r8x_core_props #(
  parameter int PAW = 10
) (
  // clock, reset and enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // program memory and wake
  input wire logic [PAW-1:0] prog_addr,
  input wire logic [15:0] prog_data,
  input wire logic wake,
  // register port
  input wire r8x_pkg::r8x_bus_req_t bus_req,
  input wire logic [15:0] bus_rdata,
  // status
  input wire logic halted,
  input wire logic watchdog_timeout_flag,
  input wire logic power_down_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  rdata_idle_a: assert property (ce && $past(ce) && !$past(bus_req.rd) |-> bus_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  status_mirror_a: assert property (ce && $past(ce) && $past(bus_req.rd) &&
    $past(bus_req.addr) == r8x_pkg::REG_STATUS
    |-> bus_rdata[6:4] == $past({halted, watchdog_timeout_flag, power_down_flag}))
    else $error("status read disagrees with flag pins");
  addr_hold_a: assert property (ce && $changed(prog_addr) |=> $stable(prog_addr) [*3])
    else $error("program address changed inside an instruction cycle");
  halt_freeze_a: assert property (halted && $past(halted, 2) |-> $stable(prog_addr))
    else $error("fetch advanced while halted");
  halt_flags_a: assert property ($rose(halted) |-> power_down_flag && !watchdog_timeout_flag)
    else $error("power down entered with wrong flags");
  pd_rise_a: assert property ($rose(power_down_flag) |-> $rose(halted))
    else $error("power down flag set without halting");
  wake_leave_a: assert property (ce && halted && wake |=> !halted)
    else $error("wake did not end power down");
  halted_pd_a: assert property (halted |-> power_down_flag)
    else $error("halted without power down flag");

  cover property ($rose(halted));
  cover property ($fell(power_down_flag));
  cover property (bus_req.rd && bus_req.addr == r8x_pkg::REG_STATUS);
endmodule

bind r8x_core r8x_core_props #(.PAW(PAW)) u_props (
  .clk(clk), .reset(reset), .ce(ce), .prog_addr(prog_addr), .prog_data(prog_data),
  .wake(wake), .bus_req(bus_req), .bus_rdata(bus_rdata), .halted(halted),
  .watchdog_timeout_flag(watchdog_timeout_flag), .power_down_flag(power_down_flag)
);

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic wake = 1'b0;
  logic [9:0] prog_addr;
  logic [15:0] prog_data;
  r8x_pkg::r8x_bus_req_t bus_req = '0;
  logic [15:0] bus_rdata;
  logic halted;
  logic watchdog_timeout_flag;
  logic power_down_flag;
  logic [15:0] rom [0:1023];
  logic [15:0] got;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  always #4 clk = ~clk;
  // zero-latency program memory, well inside the allowed two clocks
  assign prog_data = rom[prog_addr];

  r8x_core #(.PAW(10), .STACK_DEPTH(4), .WDT_LIMIT(8)) DUT (
    .clk(clk), .reset(reset), .ce(ce), .prog_addr(prog_addr), .prog_data(prog_data),
    .wake(wake), .bus_req(bus_req), .bus_rdata(bus_rdata), .halted(halted),
    .watchdog_timeout_flag(watchdog_timeout_flag), .power_down_flag(power_down_flag)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] ins(input r8x_pkg::r8x_op_t op, input logic [9:0] f);
    return {op, f};
  endfunction

  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
    d = bus_rdata;
  endtask

  // reset, start the core, let it run n clocks
  task automatic go(input int n);
    @(posedge clk);
    reset <= 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    bus_wr(r8x_pkg::REG_CTRL, 16'h0001);
    repeat (n) @(posedge clk);
  endtask

  task automatic s_bus();
    go(0);
    bus_wr(r8x_pkg::REG_CTRL, 16'h0004);
    bus_rd(r8x_pkg::REG_CTRL, got);
    chk("ctrl", 16'h0000, got);
    bus_rd(8'h14, got);
    chk("unmapped", 16'h0000, got);
  endtask

  task automatic s_alu();
    rom = '{default: 16'h0000};
    rom[0] = ins(r8x_pkg::OP_MOV_I, 10'h081);
    rom[1] = ins(r8x_pkg::OP_RLCA, 10'h005);
    rom[2] = ins(r8x_pkg::OP_RRA, 10'h005);
    rom[3] = ins(r8x_pkg::OP_ADD_I, 10'h07f);
    rom[4] = ins(r8x_pkg::OP_XOR_I, 10'h080);
    rom[5] = ins(r8x_pkg::OP_INCA, 10'h005);
    rom[6] = ins(r8x_pkg::OP_SWAPA, 10'h005);
    rom[7] = ins(r8x_pkg::OP_JMP, 10'h007);
    go(80);
    bus_rd(r8x_pkg::REG_ACC, got);
    chk("alu acc", 16'h0010, got);
    bus_rd(r8x_pkg::REG_STATUS, got);
    chk("alu flags", 16'h000a, got);
  endtask

  task automatic s_flow();
    rom = '{default: 16'h0000};
    rom[0] = ins(r8x_pkg::OP_CALL, 10'h005);
    rom[1] = ins(r8x_pkg::OP_ADD_I, 10'h001);
    rom[2] = ins(r8x_pkg::OP_SET, 10'h006);
    rom[5] = ins(r8x_pkg::OP_RETA, 10'h040);
    rom[255] = ins(r8x_pkg::OP_JMP, 10'h0ff);
    go(80);
    bus_rd(r8x_pkg::REG_ACC, got);
    chk("return acc", 16'h0041, got);
    bus_rd(r8x_pkg::REG_PC, got);
    chk("pc", 16'h00ff, got);
  endtask

  task automatic s_skip();
    rom = '{default: 16'h0000};
    rom[1] = ins(r8x_pkg::OP_SETB, 10'h385);
    rom[2] = ins(r8x_pkg::OP_SZB, 10'h385);
    rom[3] = ins(r8x_pkg::OP_ADD_I, 10'h001);
    rom[4] = ins(r8x_pkg::OP_SNZB, 10'h005);
    rom[5] = ins(r8x_pkg::OP_ADD_I, 10'h002);
    rom[6] = ins(r8x_pkg::OP_CLRB, 10'h385);
    rom[7] = ins(r8x_pkg::OP_SDZA, 10'h005);
    rom[8] = ins(r8x_pkg::OP_ADD_I, 10'h004);
    rom[9] = ins(r8x_pkg::OP_SZA, 10'h005);
    rom[10] = ins(r8x_pkg::OP_ADD_I, 10'h008);
    rom[11] = ins(r8x_pkg::OP_ADD_I, 10'h010);
    rom[12] = ins(r8x_pkg::OP_JMP, 10'h00c);
    go(120);
    bus_rd(r8x_pkg::REG_ACC, got);
    chk("skip acc", 16'h0010, got);
    bus_rd(r8x_pkg::REG_STATUS, got);
    chk("skip flags", 16'h0000, got);
  endtask

  task automatic s_wdt();
    r8x_pkg::r8x_op_t seq [4][3] = '{
      '{r8x_pkg::OP_CLRWDT1, r8x_pkg::OP_NOP, r8x_pkg::OP_CLRWDT2},
      '{r8x_pkg::OP_NOP, r8x_pkg::OP_CLRWDT2, r8x_pkg::OP_CLRWDT1},
      '{r8x_pkg::OP_CLRWDT1, r8x_pkg::OP_CLRWDT1, r8x_pkg::OP_NOP},
      '{r8x_pkg::OP_CLRWDT, r8x_pkg::OP_NOP, r8x_pkg::OP_NOP}};
    logic [15:0] pd_exp [4] = '{16'h0001, 16'h0000, 16'h0001, 16'h0000};
    for (int k = 0; k < 4; k++) begin
      rom = '{default: 16'h0000};
      rom[0] = ins(r8x_pkg::OP_HALT, 10'h000);
      for (int j = 0; j < 3; j++) rom[j+1] = ins(seq[k][j], 10'h000);
      rom[4] = ins(r8x_pkg::OP_JMP, 10'h004);
      go(2);
      for (int t = 0; t < 100 && halted !== 1'b1; t++) @(posedge clk);
      chk("halt flags", 16'h0005, {13'h0, halted, watchdog_timeout_flag, power_down_flag});
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      repeat (40) @(posedge clk);
      chk("flags after clear", pd_exp[k], {13'h0, halted, watchdog_timeout_flag, power_down_flag});
    end
  endtask

  task automatic s_tbl();
    logic [15:0] w;
    for (int k = 0; k < 2; k++) begin
      rom = '{default: 16'h0000};
      rom[0] = ins(r8x_pkg::OP_CLR, 10'h007);
      rom[1] = ins(k ? r8x_pkg::OP_TRDC : r8x_pkg::OP_TRDL, 10'h005);
      rom[2] = ins(r8x_pkg::OP_JMP, 10'h002);
      rom[10'h300] = 16'ha5c3;
      w = k ? rom[0] : rom[10'h300];
      go(60);
      bus_rd(r8x_pkg::REG_ACC, got);
      chk("table low", {8'h00, w[7:0]}, got);
      bus_rd(r8x_pkg::REG_TABLE_HIGH_BYTE, got);
      chk("table high", {8'h00, w[15:8]}, got);
    end
  endtask

  // skip not taken, skip taken, jump: pc read at a fixed clock count
  task automatic s_time();
    rom = '{default: 16'h0000};
    rom[0] = ins(r8x_pkg::OP_SNZB, 10'h005);
    rom[1] = ins(r8x_pkg::OP_SZ, 10'h005);
    rom[3] = ins(r8x_pkg::OP_JMP, 10'h010);
    rom[16] = ins(r8x_pkg::OP_MOV_I, 10'h030);
    rom[17] = ins(r8x_pkg::OP_SUB_I, 10'h010);
    go(23);
    bus_rd(r8x_pkg::REG_PC, got);
    chk("cycle count pc", 16'h0011, got);
    bus_rd(r8x_pkg::REG_ACC, got);
    chk("subtract acc", 16'h0020, got);
    bus_rd(r8x_pkg::REG_STATUS, got);
    chk("subtract flags", 16'h0003, got);
  endtask

  initial begin
    s_bus();
    s_alu();
    s_flow();
    s_skip();
    s_wdt();
    s_tbl();
    s_time();
    print_verdict();
  end
endmodule
